// ===== sepp_params.svh
// Named constants of the serial EEPROM front end.
// Assumes inclusion by bare name from the package and sepp_core.
`ifndef SEPP_PARAMS_SVH
`define SEPP_PARAMS_SVH

`define SEPP_OP_ARM 8'h06
`define SEPP_OP_DISARM 8'h04
`define SEPP_OP_ST_FETCH 8'h05
`define SEPP_OP_ST_STORE 8'h01
`define SEPP_OP_ARR_RD 8'h03
`define SEPP_OP_ARR_WR 8'h02
`define SEPP_OP_ID_RD 8'h83
`define SEPP_OP_ID_WR 8'h82

`define SEPP_ST_BUSY 0
`define SEPP_ST_LATCH 1
`define SEPP_ST_GUARD_LO 2
`define SEPP_ST_GUARD_HI 3
`define SEPP_ST_LOCK 7

`define SEPP_GUARD_NONE 2'h0
`define SEPP_GUARD_QTR 2'h1
`define SEPP_GUARD_HALF 2'h2
`define SEPP_GUARD_ALL 2'h3
`define SEPP_QTR_BASE 16'hc000
`define SEPP_HALF_BASE 16'h8000

`define SEPP_HDR_SHORT 3'h1
`define SEPP_HDR_LONG 3'h3
`define SEPP_NEED_STATUS 3'h2
`define SEPP_NEED_ARRAY 3'h4
`define SEPP_BYTE_MAX 3'h7

`define SEPP_PROG_TIME_US 100
`define SEPP_CLK_PERIOD_NS 4

`endif

// ===== sepp_pkg.sv
// Types shared by the serial EEPROM front end.
// Assumes sepp_params.svh is on the include path.
`include "sepp_params.svh"
package sepp_pkg;
    typedef enum logic [1:0] {
        SEPP_PH_CMD = 2'b00,
        SEPP_PH_BODY = 2'b01,
        SEPP_PH_IGNORE = 2'b10
    } sepp_phase_e;
endpackage

// ===== sepp_sync.sv
// Two-flop synchroniser, one chain per bit.
// Assumes asynchronous inputs and a single destination clock.
`timescale 1ns/1ps
module sepp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta[i] <= d[i];
                    q[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule

// ===== sepp_fifo.sv
// Flip-flop FIFO with a registered output word.
// Assumes one clock; the drain side may stall at will.
`timescale 1ns/1ps
module sepp_fifo #(
    parameter int W = 24,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = count < (AW+1)'(D);
    assign push = in_valid & in_ready;
    assign pop = (count != '0) & (~out_valid | out_ready);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem[rd_ptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

// ===== sepp_core.sv
// Serial EEPROM front end: pin sampling, hold, protocol checks, status.
// Assumes the array answers arr_rd_data within two clocks of arr_addr.
//
// Contract
// - Selected means active; standby after deselect only when not busy.
// - Both clock modes work: idle low or idle high.
// - Input sampled on rising clock edges, output changes on falling.
// - Pause starts only when hold is low with clock low.
// - While paused: output high impedance, clock and input ignored.
// - Pause ends when hold high and clock low.
// - Deselect during pause abandons the transfer.
// - After power-up, unselected until a select falling edge.
// - Program commands need latch, whole bytes, data byte, clean end.
// - Select rising off a byte boundary discards a program command.
// - Read commands shift data out until select rises.
// - Status: lock b7, guards b3 b2, latch b1, busy b0, rest zero.
// - Busy reads one from program decode until its cycle ends.
// - Program commands execute only with the latch set.
// - Arm sets latch; disarm, program completion and power-up clear it.
// - Guard bits persist and change only by a status store while not frozen.
// - Guard codes refuse writes starting in none, top quarter, top half, all plus ID.
// - Lock clear: status store accepted whatever the protect pin.
// - Lock set and protect low: status store discarded, bits frozen.
// - Frozen by lock or pin first; left only when pin goes high.
// - Unknown opcode: ignore everything until deselect.
// - Output MSB first; high impedance unless sending read data.
// - Status fetch answered at any time, even while busy.
`timescale 1ns/1ps
`include "sepp_params.svh"
module sepp_core import sepp_pkg::*; #(
    parameter int PROG_CYCLES =
        `SEPP_PROG_TIME_US * 1000 / `SEPP_CLK_PERIOD_NS,
    parameter logic [1:0] GUARD_INIT = 2'h0,
    parameter logic LOCK_INIT = 1'b0,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe_n,
    output logic standby,
    output logic [15:0] arr_addr,
    output logic arr_id_page,
    input wire logic [7:0] arr_rd_data,
    output logic [23:0] wdata,
    output logic wdata_valid,
    input wire logic wdata_ready,
    output logic arr_commit,
    output logic arr_abort
);
    localparam int CW = $clog2(PROG_CYCLES + 1);

    // ==========================================================
    // Pin sampling and edge detection
    logic [4:0] pin_s;
    logic s_sclk, s_cs_n, s_hold_n, s_wp_n, s_mosi;
    logic sclk_q, cs_q, armed, paused;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall, selected, go;

    sepp_sync #(.W(5)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({sclk, cs_n, hold_n, wp_n, mosi}),
        .q(pin_s)
    );
    assign {s_sclk, s_cs_n, s_hold_n, s_wp_n, s_mosi} = pin_s;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= 1'b0;
            cs_q <= 1'b0;
        end else begin
            sclk_q <= s_sclk;
            cs_q <= s_cs_n;
        end
    end
    // Edges only; the clock's idle level is irrelevant.
    assign sclk_rise = s_sclk & ~sclk_q;
    assign sclk_fall = ~s_sclk & sclk_q;
    assign cs_rise = s_cs_n & ~cs_q;
    assign cs_fall = ~s_cs_n & cs_q;

    // A select held low through power-up never produces a falling edge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed <= 1'b0;
        end else if (cs_fall) begin
            armed <= 1'b1;
        end
    end
    assign selected = armed & ~s_cs_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            paused <= 1'b0;
        end else if (s_cs_n) begin
            paused <= 1'b0;
        end else if (!paused && !s_hold_n && !s_sclk) begin
            paused <= 1'b1;
        end else if (paused && s_hold_n && !s_sclk) begin
            paused <= 1'b0;
        end
    end
    assign go = selected & ~paused;

    // ==========================================================
    // Command decode helpers
    logic [7:0] opcode;
    sepp_phase_e phase;
    logic [2:0] bit_cnt, byte_cnt;
    logic [7:0] shift_in, nb, status, stat_new;
    logic [15:0] hdr_addr;
    logic busy, latch, lock, frozen, overrun, pend_status;
    logic [1:0] guard;
    logic byte_done, push, fifo_in_ready, rd_slot, rd_load;

    function automatic logic op_known(input logic [7:0] op);
        return op == `SEPP_OP_ARM || op == `SEPP_OP_DISARM ||
               op == `SEPP_OP_ST_FETCH || op == `SEPP_OP_ST_STORE ||
               op == `SEPP_OP_ARR_RD || op == `SEPP_OP_ARR_WR ||
               op == `SEPP_OP_ID_RD || op == `SEPP_OP_ID_WR;
    endfunction
    function automatic logic op_rd(input logic [7:0] op);
        return op == `SEPP_OP_ST_FETCH || op == `SEPP_OP_ARR_RD ||
               op == `SEPP_OP_ID_RD;
    endfunction
    function automatic logic op_bulk(input logic [7:0] op);
        return op == `SEPP_OP_ARR_WR || op == `SEPP_OP_ID_WR;
    endfunction

    assign byte_done = go & sclk_rise & (phase != SEPP_PH_IGNORE) &
                       (bit_cnt == `SEPP_BYTE_MAX);
    assign nb = {shift_in[6:0], s_mosi};
    assign status = {lock, 3'b000, guard, latch, busy};
    assign frozen = lock & ~s_wp_n;

    // ==========================================================
    // Bit and byte framing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= SEPP_PH_CMD;
            bit_cnt <= '0;
            byte_cnt <= '0;
            shift_in <= '0;
            opcode <= '0;
            hdr_addr <= '0;
        end else if (!selected) begin
            phase <= SEPP_PH_CMD;
            bit_cnt <= '0;
            byte_cnt <= '0;
        end else if (go && sclk_rise && phase != SEPP_PH_IGNORE) begin
            shift_in <= nb;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
                if (byte_cnt != `SEPP_BYTE_MAX) begin
                    byte_cnt <= byte_cnt + 3'h1;
                end
                case (phase)
                    SEPP_PH_CMD: begin
                        opcode <= nb;
                        // Array reads are refused while a cycle runs.
                        if (!op_known(nb) || (busy && op_rd(nb) &&
                            nb != `SEPP_OP_ST_FETCH)) begin
                            phase <= SEPP_PH_IGNORE;
                        end else begin
                            phase <= SEPP_PH_BODY;
                        end
                    end
                    SEPP_PH_BODY: begin
                        if (byte_cnt == 3'h1) begin
                            hdr_addr[15:8] <= nb;
                        end
                        if (byte_cnt == 3'h2) begin
                            hdr_addr[7:0] <= nb;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Read data out and array address
    assign rd_slot = go & (phase == SEPP_PH_BODY) & op_rd(opcode) &
        (byte_cnt >= ((opcode == `SEPP_OP_ST_FETCH) ?
                      `SEPP_HDR_SHORT : `SEPP_HDR_LONG));
    assign rd_load = rd_slot & sclk_fall & (bit_cnt == 3'h0);
    assign push = byte_done & (phase == SEPP_PH_BODY) & op_bulk(opcode) &
                  (byte_cnt >= `SEPP_HDR_LONG);

    logic [7:0] out_sh;
    logic out_live;
    logic [7:0] out_byte;
    assign out_byte = (opcode == `SEPP_OP_ST_FETCH) ? status : arr_rd_data;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            miso <= 1'b0;
            miso_oe_n <= 1'b1;
            out_sh <= '0;
            out_live <= 1'b0;
        end else if (!rd_slot) begin
            miso_oe_n <= 1'b1;
            out_live <= out_live & selected;
        end else if (rd_load) begin
            miso <= out_byte[7];
            out_sh <= {out_byte[6:0], 1'b0};
            miso_oe_n <= 1'b0;
            out_live <= 1'b1;
        end else begin
            // A pause must not cost the bit already on the line.
            miso_oe_n <= ~out_live;
            if (sclk_fall) begin
                miso <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            arr_addr <= '0;
            arr_id_page <= 1'b0;
        end else if (byte_done && phase == SEPP_PH_BODY &&
                     byte_cnt == 3'h2) begin
            arr_addr <= {hdr_addr[15:8], nb};
            arr_id_page <= opcode[7];
        end else if ((rd_load && opcode != `SEPP_OP_ST_FETCH) || push) begin
            arr_addr <= arr_addr + 16'h0001;
        end
    end

    // ==========================================================
    // Write data buffering toward the array
    // The link cannot be stalled, so a full buffer poisons the command.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overrun <= 1'b0;
            stat_new <= '0;
        end else begin
            if (cs_fall) begin
                overrun <= 1'b0;
            end else if (push && !fifo_in_ready) begin
                overrun <= 1'b1;
            end
            if (byte_done && phase == SEPP_PH_BODY && byte_cnt == 3'h1 &&
                opcode == `SEPP_OP_ST_STORE) begin
                stat_new <= nb;
            end
        end
    end

    sepp_fifo #(.W(24), .D(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_data({arr_addr, nb}),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .out_data(wdata),
        .out_valid(wdata_valid),
        .out_ready(wdata_ready)
    );

    // ==========================================================
    // Command completion at select rising
    logic end_ok, arm_ok, disarm_ok, prog_ok, prot, enough;
    logic [CW-1:0] cyc_cnt;
    logic busy_end;

    assign end_ok = cs_rise & armed & ~paused & (phase == SEPP_PH_BODY) &
                    (bit_cnt == 3'h0);
    assign arm_ok = end_ok & (opcode == `SEPP_OP_ARM);
    assign disarm_ok = end_ok & (opcode == `SEPP_OP_DISARM);
    assign enough = (opcode == `SEPP_OP_ST_STORE) ?
        (byte_cnt >= `SEPP_NEED_STATUS) : (byte_cnt >= `SEPP_NEED_ARRAY);

    always_comb begin
        prot = 1'b0;
        if (opcode == `SEPP_OP_ID_WR) begin
            prot = (guard == `SEPP_GUARD_ALL);
        end else if (opcode == `SEPP_OP_ARR_WR) begin
            case (guard)
                `SEPP_GUARD_QTR: prot = hdr_addr >= `SEPP_QTR_BASE;
                `SEPP_GUARD_HALF: prot = hdr_addr >= `SEPP_HALF_BASE;
                `SEPP_GUARD_ALL: prot = 1'b1;
                default: prot = 1'b0;
            endcase
        end
    end

    assign prog_ok = end_ok & (op_bulk(opcode) |
        (opcode == `SEPP_OP_ST_STORE)) & enough & latch & ~busy &
        ~overrun & ~prot &
        ~((opcode == `SEPP_OP_ST_STORE) & frozen);
    assign busy_end = busy & (cyc_cnt == '0);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            cyc_cnt <= '0;
        end else if (prog_ok) begin
            busy <= 1'b1;
            cyc_cnt <= CW'(PROG_CYCLES - 1);
        end else if (busy_end) begin
            busy <= 1'b0;
        end else if (busy) begin
            cyc_cnt <= cyc_cnt - CW'(1);
        end
    end

    // A set arriving with a clear wins.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            latch <= 1'b0;
        end else if (arm_ok) begin
            latch <= 1'b1;
        end else if (disarm_ok || busy_end) begin
            latch <= 1'b0;
        end
    end

    // Guard and lock take their new value when the cycle completes.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            guard <= GUARD_INIT;
            lock <= LOCK_INIT;
            pend_status <= 1'b0;
        end else if (prog_ok && opcode == `SEPP_OP_ST_STORE) begin
            pend_status <= 1'b1;
        end else if (busy_end && pend_status) begin
            pend_status <= 1'b0;
            guard <= {stat_new[`SEPP_ST_GUARD_HI],
                      stat_new[`SEPP_ST_GUARD_LO]};
            lock <= stat_new[`SEPP_ST_LOCK];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            standby <= 1'b1;
            arr_commit <= 1'b0;
            arr_abort <= 1'b0;
        end else begin
            standby <= ~selected & ~busy;
            arr_commit <= prog_ok & op_bulk(opcode);
            arr_abort <= cs_rise & armed & (phase == SEPP_PH_BODY) &
                         op_bulk(opcode) & ~prog_ok;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_hiz_idle;
        !rd_slot |=> miso_oe_n;
    endproperty
    a_hiz_idle: assert property (p_hiz_idle)
        else $error("output driven outside read data");
    property p_pause_hiz;
        paused |=> miso_oe_n;
    endproperty
    a_pause_hiz: assert property (p_pause_hiz)
        else $error("output driven while paused");
    property p_pause_in;
        $rose(paused) |-> $past(!s_hold_n && !s_sclk);
    endproperty
    a_pause_in: assert property (p_pause_in)
        else $error("pause entered with clock high or hold high");
    property p_pause_out;
        $fell(paused) |-> $past((s_hold_n && !s_sclk) || s_cs_n);
    endproperty
    a_pause_out: assert property (p_pause_out)
        else $error("pause left without cause");
    property p_desel_abandon;
        paused && s_cs_n |=> !paused && phase == SEPP_PH_CMD;
    endproperty
    a_desel_abandon: assert property (p_desel_abandon)
        else $error("paused transfer survived deselect");
    property p_arm_edge;
        $rose(armed) |-> $past(cs_fall);
    endproperty
    a_arm_edge: assert property (p_arm_edge)
        else $error("selected without a falling edge");
    property p_busy_cause;
        $rose(busy) |-> $past(cs_rise && latch && bit_cnt == 3'h0);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("program cycle without latch or at bad boundary");
    property p_busy_hold;
        $rose(busy) |-> busy [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("program cycle too short");
    property p_latch_end;
        $fell(busy) && !$past(arm_ok) |-> !latch;
    endproperty
    a_latch_end: assert property (p_latch_end)
        else $error("latch survived program completion");
    property p_frozen_guard;
        frozen && !pend_status |=> $stable(guard) && $stable(lock);
    endproperty
    a_frozen_guard: assert property (p_frozen_guard)
        else $error("guard bits changed while frozen");
    property p_standby;
        busy |=> !standby;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby during program cycle");
    property p_ignore;
        phase == SEPP_PH_IGNORE |=> miso_oe_n && !busy || $past(busy);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("activity after unknown opcode");

    c_commit: cover property (arr_commit);
    c_status_out: cover property (rd_load && opcode == `SEPP_OP_ST_FETCH);
    c_pause: cover property ($rose(paused) ##[1:200] $fell(paused));
    c_abort: cover property (arr_abort);
endmodule

// ===== sepp_host.sv
// Serial bus master model that drives the select, clock and data pins.
// Assumes the 4 ns system clock; one link bit lasts 8 clocks (32 ns).
`timescale 1ns/1ps
module sepp_host (
    input wire logic clk,
    input wire logic miso,
    input wire logic miso_oe_n,
    output logic sclk,
    output logic cs_n,
    output logic mosi
);
    logic idle_hi;

    // Select starts low so that the power-up check has something to refuse.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        mosi = 1'b0;
        idle_hi = 1'b0;
    end

    // =================================================================
    // Frame control
    task automatic start(input logic mode3);
        idle_hi = mode3;
        sclk <= mode3;
        repeat (4) @(posedge clk);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Low phase of 5 clocks, high of 3: the output has settled by then.
    task automatic bits(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sclk <= 1'b0;
            mosi <= tx[i];
            repeat (5) @(posedge clk);
            rx[i] = miso_oe_n ? ~miso : miso;
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask

    // Clock low inside a frame: one falling edge, then the line rests.
    task automatic park();
        sclk <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // After deselect the data line is flipped so a stale level is never read.
    task automatic stop();
        sclk <= idle_hi;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ===== spi_eeprom_protocol_protect_tb.sv
// Self-checking bench of the serial EEPROM front end.
// Assumes sepp_host as bus master and a reduced program cycle length.
`timescale 1ns/1ps
module spi_eeprom_protocol_protect_tb;
    import sepp_pkg::*;
    logic clk, arst_n, hold_n, wp_n, wdata_ready;
    logic sclk, cs_n, mosi, miso, miso_oe_n, standby, arr_id_page;
    logic wdata_valid, arr_commit, arr_abort;
    logic [15:0] arr_addr;
    logic [23:0] wdata;
    logic [7:0] arr_rd_data = 8'h00;
    logic [7:0] rx;
    int n_mismatch = 0, n_compared = 0, n_commit = 0, n_abort = 0, c, a;

    sepp_core #(.PROG_CYCLES(200)) i_dut (.clk(clk), .arst_n(arst_n),
        .sclk(sclk), .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n),
        .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
        .standby(standby), .arr_addr(arr_addr), .arr_id_page(arr_id_page),
        .arr_rd_data(arr_rd_data), .wdata(wdata), .wdata_valid(wdata_valid),
        .wdata_ready(wdata_ready), .arr_commit(arr_commit),
        .arr_abort(arr_abort));
    sepp_host i_host (.clk(clk), .miso(miso), .miso_oe_n(miso_oe_n),
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Array stand-in: data is a fixed function of the address.
    always @(posedge clk) begin
        arr_rd_data <= arr_addr[7:0] ^ 8'h5a;
        if (arr_commit === 1'b1) n_commit++;
        if (arr_abort === 1'b1) n_abort++;
    end

    // =================================================================
    // Helpers
    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic fetch(input logic [7:0] exp);
        i_host.start(1'b1);
        i_host.bits(8'h05, 8, rx);
        i_host.bits(8'h00, 8, rx);
        i_host.stop();
        chk("status", {16'h0000, exp}, {16'h0000, rx});
    endtask

    task automatic op1(input logic [7:0] op);
        i_host.start(1'b0);
        i_host.bits(op, 8, rx);
        i_host.stop();
    endtask

    task automatic wr(input logic [7:0] op, input logic [15:0] ad,
                      input logic [7:0] d, input int tail);
        c = n_commit;
        a = n_abort;
        i_host.start(1'b0);
        i_host.bits(op, 8, rx);
        if (op != 8'h01) i_host.bits(ad[15:8], 8, rx);
        if (op != 8'h01) i_host.bits(ad[7:0], 8, rx);
        i_host.bits(d, 8, rx);
        i_host.bits(8'hbb, tail, rx);
        i_host.stop();
    endtask

    task automatic drain();
        wdata_ready <= 1'b1;
        repeat (40) @(posedge clk);
        wdata_ready <= 1'b0;
        repeat (300) @(posedge clk);
    endtask

    task automatic take(input logic [23:0] exp);
        for (int i = 0; i < 50 && wdata_valid !== 1'b1; i++) @(posedge clk);
        chk("fifo word", exp, wdata);
        wdata_ready <= 1'b1;
        @(posedge clk);
        wdata_ready <= 1'b0;
        @(posedge clk);
    endtask

    // =================================================================
    // Scenarios
    task automatic t_power();
        i_host.bits(8'h05, 8, rx);
        i_host.bits(8'h00, 8, rx);
        chk("oe_n unselected", 24'h1, {23'h0, miso_oe_n});
        i_host.stop();
        chk("standby", 24'h1, {23'h0, standby});
        fetch(8'h00);
    endtask

    task automatic t_arm();
        op1(8'h06);
        fetch(8'h02);
        op1(8'h04);
        fetch(8'h00);
        i_host.start(1'b0);
        i_host.bits(8'hff, 8, rx);
        i_host.bits(8'h05, 8, rx);
        i_host.bits(8'h00, 8, rx);
        chk("oe_n bad opcode", 24'h1, {23'h0, miso_oe_n});
        i_host.stop();
    endtask

    task automatic t_refuse();
        wr(8'h02, 16'h0010, 8'h11, 0);
        chk("abort", a + 1, n_abort);
        chk("commit", c, n_commit);
        op1(8'h06);
        wr(8'h02, 16'h0020, 8'h22, 3);
        chk("odd abort", a + 1, n_abort);
        chk("odd commit", c, n_commit);
        fetch(8'h02);
        drain();
    endtask

    task automatic t_write();
        op1(8'h06);
        wr(8'h02, 16'h1234, 8'haa, 8);
        chk("standby busy", 24'h0, {23'h0, standby});
        chk("commit", c + 1, n_commit);
        fetch(8'h03);
        take(24'h1234aa);
        take(24'h1235bb);
        repeat (300) @(posedge clk);
        fetch(8'h00);
    endtask

    task automatic t_guard();
        wp_n <= 1'b0;
        op1(8'h06);
        wr(8'h01, 16'h0000, 8'h04, 0);
        repeat (300) @(posedge clk);
        wp_n <= 1'b1;
        fetch(8'h04);
        op1(8'h06);
        wr(8'h02, 16'hc000, 8'h33, 0);
        chk("guarded", a + 1, n_abort);
        wr(8'h02, 16'hbfff, 8'h44, 0);
        chk("unguarded", c + 1, n_commit);
        drain();
    endtask

    task automatic t_lock();
        op1(8'h06);
        wr(8'h01, 16'h0000, 8'h8c, 0);
        repeat (300) @(posedge clk);
        fetch(8'h8c);
        wp_n <= 1'b0;
        op1(8'h06);
        wr(8'h01, 16'h0000, 8'h00, 0);
        repeat (300) @(posedge clk);
        fetch(8'h8e);
        wp_n <= 1'b1;
        wr(8'h01, 16'h0000, 8'h00, 0);
        repeat (300) @(posedge clk);
        fetch(8'h00);
    endtask

    task automatic t_hold();
        logic [7:0] hi;
        op1(8'h06);
        i_host.start(1'b0);
        i_host.bits(8'h05, 8, rx);
        i_host.bits(8'h00, 4, hi);
        i_host.park();
        hold_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk("oe_n held", 24'h1, {23'h0, miso_oe_n});
        i_host.bits(8'hff, 2, rx);
        hold_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk("oe_n sclk high", 24'h1, {23'h0, miso_oe_n});
        i_host.park();
        i_host.bits(8'h00, 4, rx);
        chk("held status", 24'h2, {16'h0, hi[7:4], rx[7:4]});
        i_host.park();
        hold_n <= 1'b0;
        repeat (6) @(posedge clk);
        i_host.stop();
        hold_n <= 1'b1;
        fetch(8'h02);
        op1(8'h04);
    endtask

    task automatic t_read();
        i_host.start(1'b0);
        i_host.bits(8'h03, 8, rx);
        i_host.bits(8'hff, 8, rx);
        i_host.bits(8'hff, 8, rx);
        i_host.bits(8'h00, 8, rx);
        chk("read ffff", 24'ha5, {16'h0, rx});
        i_host.bits(8'h00, 8, rx);
        chk("read wrap", 24'h5a, {16'h0, rx});
        i_host.stop();
        chk("oe_n after read", 24'h1, {23'h0, miso_oe_n});
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
        wdata_ready = 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_power();
        t_arm();
        t_refuse();
        t_write();
        t_guard();
        t_lock();
        t_hold();
        t_read();
        test_done();
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule
